// ===== rtl/cfg_loader_map.svh
`ifndef CFG_LOADER_MAP_SVH
`define CFG_LOADER_MAP_SVH
`define OFS_IMAGE_SEL      8'h00
`define OFS_SLAVE_BASE     8'h40
`define OFS_ADDR_OFS_CTRL  8'h42
`define OFS_PROTO_SEL      8'h44
`define OFS_ADDR_LOCK      8'hd4
`define OFS_STATUS         8'hf0
`define OFS_PASSWORD       8'hf2
`define OFS_ACCESS_CTRL    8'hf4
`define OFS_VOUT_CMD       8'hf6
`define OFS_VID_CODE       8'hf8
`define OFS_TELEM          8'hfa
`define CMD_MFR_ACCESS     8'hd0
`define BIT_PMBUS_MODE     15
`define BIT_OFS_DISABLE    6
`define BIT_ADDR_LOCK      2
`define RST_WORD           16'h0000
`define ONE_IMG            6'h01
`define NV_WORDS           64
`define IMG_WORDS          8
`define IMG_MAX            4'h5
`define PROG_LIMIT_SINGLE  5'h10
`define PROG_AFTER_MULTI   5'h02
`define CRC_POLY           16'h1021
`define CRC_INIT           16'hffff
`define VID_STEP5_MV       8'h05
`endif

// ===== rtl/cfg_loader_pkg.sv
package cfg_loader_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR  = 3'b001,
    ST_CRC  = 3'b010,
    ST_COPY = 3'b011,
    ST_RUN  = 3'b100,
    ST_FAIL = 3'b101
  } load_state_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    load_state_t st;
    logic [5:0]  ptr;
    logic [15:0] crc;
    logic [2:0]  idx;
    logic [15:0] img_sel;
    logic [15:0] slave_base;
    logic [15:0] ofs_ctrl;
    logic [15:0] proto_sel;
    logic [15:0] lock_ctrl;
    logic [15:0] pass_word;
    logic [1:0]  acc_mode;
    logic        unlocked;
    logic [15:0] vout_cmd;
    logic [7:0]  vid_code;
    logic [15:0] rdata;
    logic        rvalid;
    logic        refused;
    logic [4:0]  prog_left;
    logic        crc_fail;
  } state_t;
endpackage

// ===== rtl/cfg_loader.sv
`include "cfg_loader_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cfg_loader
  import cfg_loader_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [2:0]  PIN_INDEX_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  input  wire logic        REG_VIA_PMBUS_I,
  input  wire logic [7:0]  REG_CMD_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [15:0] REG_WDATA_I,
  input  wire logic        NV_PROG_I,
  input  wire logic        NV_MULTI_I,
  input  wire logic [15:0] NV_RDATA_I,
  output logic [5:0]       NV_ADDR_O,
  output logic [15:0]      REG_RDATA_O,
  output logic             REG_RVALID_O,
  output logic             REG_REFUSED_O,
  output logic             NV_PROG_OK_O,
  output logic [6:0]       I2C_ADDR_O,
  output logic [6:0]       PMB_ADDR_O,
  output logic             I2C_EN_O,
  output logic             PMB_EN_O,
  output logic             TEST_MODE_O,
  output logic             PMBUS_MODE_O,
  output logic [4:0]       PROTO_ID_O,
  output logic [15:0]      REF_CODE_O,
  output logic             REG_ENABLE_O,
  output logic             LOAD_DONE_O,
  output logic             CRC_FAIL_O
);
  state_t   s_ff;
  state_t   nxt_s;
  reg_req_t req;
  logic [2:0]  pin_m1_ff;
  logic [2:0]  pin_m2_ff;
  logic [2:0]  pin_m3_ff;
  logic [2:0]  pin_idx_ff;
  logic [7:0]  eff_addr;
  logic        is_telem;
  logic        wr_ok;
  logic        rd_ok;
  logic [15:0] crc_nxt;
  logic [5:0]  img_base;
  logic [6:0]  sum_idx;
  logic [27:0] scaled;
  logic [15:0] vid_mv;
  logic        ready;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  // pin strap: three stages, accept on agreement of last two
  always_ff @(posedge CLK_I)
  begin
    pin_m1_ff <= PIN_INDEX_I;
    pin_m2_ff <= pin_m1_ff;
    pin_m3_ff <= pin_m2_ff;
    if (!RSTN_I)
      pin_idx_ff <= 3'h0;
    else if (pin_m2_ff == pin_m3_ff)
      pin_idx_ff <= pin_m3_ff;
  end

  assign ready = (s_ff.st == ST_RUN);
  assign eff_addr = (REG_VIA_PMBUS_I && REG_CMD_I == `CMD_MFR_ACCESS)
                    ? REG_ADDR_I : REG_CMD_I;
  assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: eff_addr,
                 wdata: REG_WDATA_I};
  assign is_telem = (req.addr == `OFS_TELEM) || (req.addr == `OFS_STATUS);

  always_comb
  begin
    wr_ok = s_ff.unlocked && ready;
    rd_ok = s_ff.unlocked && ready;
    unique case (s_ff.acc_mode)
      2'b00: ;
      2'b01: wr_ok = 1'b0;
      2'b10: rd_ok = ready && is_telem;
      2'b11:
      begin
        wr_ok = 1'b0;
        rd_ok = ready && is_telem;
      end
    endcase
    if (req.addr == `OFS_PASSWORD && s_ff.acc_mode != 2'b11)
      wr_ok = ready;
    if (req.addr == `OFS_ACCESS_CTRL && s_ff.acc_mode == 2'b11)
      wr_ok = 1'b0;
  end

  always_comb
  begin
    crc_nxt = s_ff.crc;
    for (int b = 15; b >= 0; b--)
    begin
      if (crc_nxt[15] ^ NV_RDATA_I[b])
        crc_nxt = {crc_nxt[14:0], 1'b0} ^ `CRC_POLY;
      else
        crc_nxt = {crc_nxt[14:0], 1'b0};
    end
  end

  assign sum_idx = {1'b0, s_ff.img_sel[13:8]} + {4'h0, pin_idx_ff};
  always_comb
  begin
    if (s_ff.img_sel[3:0] <= 4'h1)
      img_base = 6'h00;
    else if (s_ff.img_sel[3:0] > `IMG_MAX)
      img_base = 6'(({1'b0, s_ff.img_sel[13:8]} + 7'(`IMG_MAX) - 7'h1)
                 * 7'(`IMG_WORDS));
    else if (pin_idx_ff >= s_ff.img_sel[2:0])
      img_base = 6'(({1'b0, s_ff.img_sel[13:8]} + 7'(s_ff.img_sel[3:0])
                 - 7'h1) * 7'(`IMG_WORDS));
    else
      img_base = 6'(sum_idx * 7'(`IMG_WORDS));
  end

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.rvalid = 1'b0;
    nxt_s.refused = 1'b0;
    unique case (s_ff.st)
      ST_IDLE:
      begin
        nxt_s.ptr = 6'h00;
        nxt_s.crc = `CRC_INIT;
        nxt_s.st = ST_HDR;
      end
      ST_HDR:
      begin
        // header word holds pointer and count
        nxt_s.img_sel = NV_RDATA_I;
        nxt_s.crc = crc_nxt;
        nxt_s.ptr = `ONE_IMG;
        nxt_s.st = ST_CRC;
      end
      ST_CRC:
      begin
        nxt_s.crc = crc_nxt;
        nxt_s.ptr = s_ff.ptr + 6'h01;
        if (s_ff.ptr == 6'(`NV_WORDS - 1))
        begin
          nxt_s.idx = 3'h0;
          nxt_s.st = (crc_nxt == 16'h0000) ? ST_COPY : ST_FAIL;
        end
      end
      ST_COPY:
      begin
        // copy chosen image into operating registers
        nxt_s.idx = s_ff.idx + 3'h1;
        unique case (s_ff.idx)
          3'h0: nxt_s.slave_base = NV_RDATA_I;
          3'h1: nxt_s.ofs_ctrl = NV_RDATA_I;
          3'h2: nxt_s.proto_sel = NV_RDATA_I;
          3'h3: nxt_s.lock_ctrl = NV_RDATA_I;
          3'h4: nxt_s.vout_cmd = NV_RDATA_I;
          default: nxt_s.st = ST_RUN;
        endcase
      end
      ST_FAIL:
      begin
        nxt_s.crc_fail = 1'b1;
        nxt_s.st = ST_RUN;
      end
      ST_RUN: ;
      default: nxt_s.st = ST_IDLE;
    endcase
    if (req.rd)
    begin
      nxt_s.rvalid = rd_ok;
      nxt_s.refused = !rd_ok;
      unique case (req.addr)
        `OFS_IMAGE_SEL:     nxt_s.rdata = s_ff.img_sel;
        `OFS_SLAVE_BASE:    nxt_s.rdata = s_ff.slave_base;
        `OFS_ADDR_OFS_CTRL: nxt_s.rdata = s_ff.ofs_ctrl;
        `OFS_PROTO_SEL:     nxt_s.rdata = s_ff.proto_sel;
        `OFS_ADDR_LOCK:     nxt_s.rdata = s_ff.lock_ctrl;
        `OFS_STATUS:        nxt_s.rdata = {8'h00, s_ff.prog_left,
                                          s_ff.crc_fail, ready, 1'b0};
        `OFS_ACCESS_CTRL:   nxt_s.rdata = {14'h0000, s_ff.acc_mode};
        `OFS_VOUT_CMD:      nxt_s.rdata = s_ff.vout_cmd;
        `OFS_VID_CODE:      nxt_s.rdata = {8'h00, s_ff.vid_code};
        `OFS_TELEM:         nxt_s.rdata = REF_CODE_O;
        default:            nxt_s.rdata = `RST_WORD;
      endcase
      if (!rd_ok)
        nxt_s.rdata = `RST_WORD;
    end
    else if (req.wr)
    begin
      nxt_s.refused = !wr_ok;
      if (wr_ok)
      begin
        unique case (req.addr)
          `OFS_IMAGE_SEL:     nxt_s.img_sel = req.wdata;
          `OFS_SLAVE_BASE:
            if (!s_ff.lock_ctrl[`BIT_ADDR_LOCK])
              nxt_s.slave_base = req.wdata;
            else
              nxt_s.refused = 1'b1;
          `OFS_ADDR_OFS_CTRL: nxt_s.ofs_ctrl = req.wdata;
          `OFS_PROTO_SEL:     nxt_s.proto_sel = req.wdata;
          `OFS_ADDR_LOCK:     nxt_s.lock_ctrl = req.wdata;
          `OFS_PASSWORD:      nxt_s.unlocked = (req.wdata == s_ff.pass_word);
          `OFS_ACCESS_CTRL:
          begin
            nxt_s.acc_mode = req.wdata[1:0];
            nxt_s.pass_word = req.wdata[15:0] & 16'hfffc;
            if (req.wdata[15:2] != 14'h0000)
              nxt_s.unlocked = 1'b0;
          end
          `OFS_VOUT_CMD:      nxt_s.vout_cmd = req.wdata;
          `OFS_VID_CODE:      nxt_s.vid_code = req.wdata[7:0];
          default:            nxt_s.refused = 1'b1;
        endcase
      end
    end
    if (NV_PROG_I && ready && s_ff.prog_left != 5'h00)
      nxt_s.prog_left = NV_MULTI_I ? `PROG_AFTER_MULTI
                                   : s_ff.prog_left - 5'h01;
    if (!RSTN_I)
    begin
      nxt_s = '0;
      nxt_s.st = ST_IDLE;
      nxt_s.unlocked = 1'b1;
      nxt_s.prog_left = `PROG_LIMIT_SINGLE;
    end
  end

  always_ff @(posedge CLK_I)
    s_ff <= nxt_s;

  assign NV_ADDR_O = (s_ff.st == ST_COPY) ? img_base + 6'(s_ff.idx)
                                          : s_ff.ptr;
  assign NV_PROG_OK_O = ready && (s_ff.prog_left != 5'h00);
  assign REG_RDATA_O = s_ff.rdata;
  assign REG_RVALID_O = s_ff.rvalid;
  assign REG_REFUSED_O = s_ff.refused;
  assign LOAD_DONE_O = ready;
  assign CRC_FAIL_O = s_ff.crc_fail;

  assign I2C_ADDR_O = s_ff.ofs_ctrl[`BIT_OFS_DISABLE] ? s_ff.slave_base[14:8]
                      : s_ff.slave_base[14:8] + {4'h0, pin_idx_ff};
  assign PMB_ADDR_O = s_ff.ofs_ctrl[`BIT_OFS_DISABLE] ? s_ff.slave_base[6:0]
                      : s_ff.slave_base[6:0] + {4'h0, pin_idx_ff};
  assign PMB_EN_O = ready && (s_ff.slave_base[6:0] != 7'h00);
  assign TEST_MODE_O = ready && (s_ff.slave_base[14:8] == 7'h00);
  assign I2C_EN_O = ready && !TEST_MODE_O;
  assign PMBUS_MODE_O = s_ff.proto_sel[`BIT_PMBUS_MODE];
  assign PROTO_ID_O = s_ff.proto_sel[12:8];
  // regulation only after a good load
  assign REG_ENABLE_O = ready && !s_ff.crc_fail;

  // lsb weights in 1/1024 mV: 640, 1000, 2000, 4000
  always_comb
  begin
    unique case (s_ff.proto_sel[14:13])
      2'b00: scaled = 28'(s_ff.vout_cmd) * 28'd640;
      2'b01: scaled = 28'(s_ff.vout_cmd) * 28'd1000;
      2'b10: scaled = 28'(s_ff.vout_cmd) * 28'd2000;
      2'b11: scaled = 28'(s_ff.vout_cmd) * 28'd4000;
    endcase
  end
  // vid: code 0 is off, else code times a 5 or 10 mV step
  assign vid_mv = (s_ff.vid_code == 8'h00) ? 16'h0000
                : (s_ff.proto_sel[8] ? 16'(s_ff.vid_code) * 16'd10
                                     : 16'(s_ff.vid_code) * 16'(`VID_STEP5_MV));
  // dac step 1.25 mV: mv*4/5, pmbus value /1280
  assign REF_CODE_O = PMBUS_MODE_O ? 16'(scaled / 28'd1280)
                                   : 16'((20'(vid_mv) * 20'd4) / 20'd5);

  a_crc_gate: assert property (REG_ENABLE_O |-> !CRC_FAIL_O)
    else $error("enable with crc fail");
  a_pmb_off: assert property ((s_ff.slave_base[6:0] == 7'h00)
    |-> !PMB_EN_O) else $error("pmbus enabled at zero");
  a_lock_hold: assert property (ready && REG_WR_I
    && s_ff.lock_ctrl[`BIT_ADDR_LOCK] && eff_addr == `OFS_SLAVE_BASE
    |=> $stable(s_ff.slave_base)) else $error("locked write");
  a_wait_load: assert property (!ready |-> !I2C_EN_O && !PMB_EN_O)
    else $error("early decode");
  a_ofs_off: assert property (s_ff.ofs_ctrl[`BIT_OFS_DISABLE]
    |-> I2C_ADDR_O == s_ff.slave_base[14:8]) else $error("offset applied");
  a_telem_only: assert property (s_ff.acc_mode == 2'b11
    && REG_WR_I && !REG_RD_I |=> REG_REFUSED_O)
    else $error("write in telemetry mode");
  a_test_mode: assert property (ready
    && s_ff.slave_base[14:8] == 7'h00 |-> TEST_MODE_O)
    else $error("no test mode");
  a_prog_count: assert property (s_ff.prog_left <= `PROG_LIMIT_SINGLE)
    else $error("budget overflow");
  c_load_ok: cover property (@(posedge CLK_I) REG_ENABLE_O);
  c_crc_bad: cover property (@(posedge CLK_I) CRC_FAIL_O);
  c_refused: cover property (@(posedge CLK_I) REG_REFUSED_O);
endmodule
`default_nettype wire

// ===== testbench/nv_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module nv_store_model
(
  input  wire logic [5:0]  addr_i,
  input  wire logic        corrupt_i,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [64];
  logic [15:0] crc;
  logic        fb;

  // header: start pointer 1, three images; image n sits at word 8*n
  function automatic logic [15:0] word_of(input int a);
    int n;
    n = a / 8;
    if (a == 0)
      return 16'h0103;
    if (n < 1 || n > 3)
      return 16'h0000;
    case (a % 8)
      0: return {1'b0, 7'(16 + n), 1'b0, 7'(64 + n)};
      1: return (n == 2) ? 16'h0040 : 16'h0000;
      2: return {1'b1, 2'(n - 1), 5'(8 + n), 8'h00};
      3: return (n == 3) ? 16'h0004 : 16'h0000;
      4: return 16'h0640;
      default: return 16'h0000;
    endcase
  endfunction

  // last word closes the check so that the residue is zero
  initial
  begin
    crc = 16'hffff;
    for (int a = 0; a < 63; a++)
    begin
      mem[a] = word_of(a);
      for (int b = 15; b >= 0; b--)
      begin
        fb = crc[15] ^ mem[a][b];
        crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
    end
    mem[63] = crc;
  end

  // one flipped bit in an unused word is enough to spoil the check
  assign rdata_o = mem[addr_i] ^ {15'h0000, corrupt_i && addr_i == 6'h05};
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cfg_loader_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic        refd;
    logic [15:0] mask;
    logic [15:0] data;
    int          due;
  } note_t;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  pin = 3'h0;
  reg_req_t    req = '0;
  logic        via = 1'b0;
  logic [7:0]  cmd = 8'h00;
  logic        prog = 1'b0;
  logic        multi = 1'b0;
  logic        bad_nv = 1'b0;
  logic [5:0]  nv_addr;
  logic [15:0] nv_data, rdata, ref_code, base;
  logic        rvalid, refused, prog_ok, i2c_en, pmb_en, test_mode;
  logic        pmb_mode, reg_en, done, crc_fail;
  logic [6:0]  i2c_addr, pmb_addr;
  logic [4:0]  proto;
  logic [2:0]  p;
  int          n, o, negs, cycles, n_mismatch, total_checks;
  note_t       notes[$];
  note_t       nt;

  always #25 clk = ~clk;

  cfg_loader uut (.CLK_I(clk), .RSTN_I(rstn), .PIN_INDEX_I(pin),
    .REG_WR_I(req.wr), .REG_RD_I(req.rd), .REG_VIA_PMBUS_I(via),
    .REG_CMD_I(cmd), .REG_ADDR_I(req.addr), .REG_WDATA_I(req.wdata),
    .NV_PROG_I(prog), .NV_MULTI_I(multi), .NV_RDATA_I(nv_data),
    .NV_ADDR_O(nv_addr), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .REG_REFUSED_O(refused), .NV_PROG_OK_O(prog_ok),
    .I2C_ADDR_O(i2c_addr), .PMB_ADDR_O(pmb_addr), .I2C_EN_O(i2c_en),
    .PMB_EN_O(pmb_en), .TEST_MODE_O(test_mode), .PMBUS_MODE_O(pmb_mode),
    .PROTO_ID_O(proto), .REF_CODE_O(ref_code), .REG_ENABLE_O(reg_en),
    .LOAD_DONE_O(done), .CRC_FAIL_O(crc_fail));

  nv_store_model store (.addr_i(nv_addr), .corrupt_i(bad_nv),
    .rdata_o(nv_data));

  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request is held over one taking edge; the answer is due one cycle on
  task automatic access(input logic w, input logic [7:0] c,
      input logic [15:0] d, input logic rf, input logic [15:0] m);
    @(posedge clk);
    req.wr <= w;
    req.rd <= !w;
    cmd <= c;
    req.wdata <= d;
    notes.push_back('{w, rf, m, w ? 16'h0000 : d, negs + 2});
  endtask

  task automatic idle(input int k);
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    via <= 1'b0;
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pulse(input logic mu);
    @(posedge clk);
    prog <= 1'b1;
    multi <= mu;
    @(posedge clk);
    prog <= 1'b0;
    @(negedge clk);
  endtask

  task automatic powerup(input logic [2:0] pv, input logic bad);
    @(posedge clk);
    rstn <= 1'b0;
    pin <= pv;
    bad_nv <= bad;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // early read lands while the store is still being checked, before the copy
    access(1'b0, 8'h40, 16'h0000, 1'b1, 16'hffff);
    idle(2);
    chk_bit("enable", 1'b0, reg_en);
    repeat (100) @(posedge clk);
    @(negedge clk);
    chk_bit("crc_fail", bad, crc_fail);
    chk_bit("enable", !bad, reg_en);
    if (!bad)
      chk_bit("done", 1'b1, done);
  endtask

  function automatic logic [15:0] ref_of(input int r);
    case (r)
      0: return 16'h0320;
      1: return 16'h04e2;
      2: return 16'h09c4;
      default: return 16'h1388;
    endcase
  endfunction

  always @(negedge clk)
  begin
    negs++;
    while (notes.size() > 0 && notes[0].due == negs)
    begin
      nt = notes.pop_front();
      chk_bit("refused", nt.refd, refused);
      if (!nt.wr && !nt.refd)
        chk_bit("rvalid", 1'b1, rvalid);
      if (!nt.wr)
        chk_word("rdata", nt.data, rdata & nt.mask);
    end
  end

  // generous ceiling: the whole run needs about thirteen hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 8000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  initial
  begin
    void'($urandom(32'hce1d));
    for (int i = 0; i < 4; i++)
    begin
      p = (i < 3) ? 3'(i) : 3'($urandom % 8);
      n = (p < 2) ? p + 1 : 3;
      o = (n == 2) ? 0 : p;
      powerup(p, 1'b0);
      base = store.word_of(8 * n);
      access(1'b0, 8'h40, base, 1'b0, 16'hffff);
      access(1'b0, 8'h00, 16'h0103, 1'b0, 16'hffff);
      access(1'b0, 8'h42, store.word_of(8 * n + 1), 1'b0, 16'hffff);
      access(1'b0, 8'hf0, 16'h0082, 1'b0, 16'h00fe);
      idle(0);
      @(posedge clk);
      via <= 1'b1;
      req.addr <= 8'h44;
      access(1'b0, 8'hd0, store.word_of(8 * n + 2), 1'b0, 16'hffff);
      idle(1);
      chk_word("i2c", 16'(16 + n + o), {9'h000, i2c_addr});
      chk_word("pmb", 16'(64 + n + o), {9'h000, pmb_addr});
      chk_word("proto", 16'(8 + n), {11'h000, proto});
      chk_bit("pmbus_mode", 1'b1, pmb_mode);
      chk_bit("test_mode", 1'b0, test_mode);
      chk_bit("pmb_en", 1'b1, pmb_en & i2c_en);
      if (n == 3)
        access(1'b1, 8'h40, 16'h1541, 1'b1, 16'h0000);
      if (n == 1)
      begin
        for (int r = 0; r < 4; r++)
        begin
          access(1'b1, 8'h44, {1'b1, 2'(r), 5'h09, 8'h00}, 1'b0, 16'h0000);
          idle(3);
          chk_word("ref", ref_of(r), ref_code);
        end
        // vid path: code 100 is 1000 mV at 10 mV steps, 500 mV at 5 mV
        access(1'b1, 8'h44, 16'h0100, 1'b0, 16'h0000);
        access(1'b1, 8'hf8, 16'h0064, 1'b0, 16'h0000);
        idle(2);
        chk_bit("pmbus_mode", 1'b0, pmb_mode);
        chk_word("ref", 16'h0320, ref_code);
        access(1'b1, 8'h44, 16'h0000, 1'b0, 16'h0000);
        access(1'b0, 8'hfa, 16'h0190, 1'b0, 16'hffff);
        idle(2);
        chk_word("ref", 16'h0190, ref_code);
        // each base set in turn to the reserved zero value
        access(1'b1, 8'h40, 16'h1500, 1'b0, 16'h0000);
        idle(2);
        chk_bit("pmb_en", 1'b0, pmb_en);
        access(1'b1, 8'h40, 16'h0031, 1'b0, 16'h0000);
        access(1'b1, 8'h10, 16'h0031, 1'b1, 16'h0000);
        idle(2);
        chk_bit("test_mode", 1'b1, test_mode);
      end
      idle(2);
    end
    for (int m = 1; m < 4; m++)
    begin
      powerup(3'h0, 1'b0);
      access(1'b1, 8'hf4, 16'(m), 1'b0, 16'h0000);
      access(1'b0, 8'h40, m >= 2 ? 16'h0000 : 16'h1141, m >= 2,
        16'hffff);
      access(1'b0, 8'hfa, 16'h0000, 1'b0, 16'h0000);
      if (m != 2)
        access(1'b1, 8'h42, 16'h0040, 1'b1, 16'h0000);
      idle(2);
    end
    // a nonzero password locks; only the matching word reopens access
    powerup(3'h0, 1'b0);
    access(1'b1, 8'hf4, 16'h1234, 1'b0, 16'h0000);
    access(1'b0, 8'h40, 16'h0000, 1'b1, 16'hffff);
    access(1'b1, 8'hf2, 16'h1230, 1'b0, 16'h0000);
    access(1'b0, 8'h40, 16'h0000, 1'b1, 16'hffff);
    access(1'b1, 8'hf2, 16'h1234, 1'b0, 16'h0000);
    access(1'b0, 8'h40, 16'h1141, 1'b0, 16'hffff);
    idle(2);
    // budget is spent once the load is done, here with regulation held off by a bad store
    powerup(3'h0, 1'b1);
    for (int k = 1; k <= 16; k++)
    begin
      pulse(1'b0);
      chk_bit("prog_ok", k < 16, prog_ok);
    end
    powerup(3'h0, 1'b1);
    pulse(1'b1);
    chk_bit("prog_ok", 1'b1, prog_ok);
    for (int k = 1; k <= 2; k++)
    begin
      pulse(1'b0);
      chk_bit("prog_ok", k < 2, prog_ok);
    end
    complete_run();
  end
endmodule
`default_nettype wire
